// >>> clcomm_motor_model.sv
// motor winding model: back-emf zero cross level and current samples
`timescale 1ns/1ns
module clcomm_motor_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic run,
  input wire logic [15:0] half_period,
  input wire logic cur_req,
  input wire logic [11:0] cur_level,
  output logic zero_cross_level,
  output logic [11:0] phase_current,
  output logic current_valid
);
  logic [15:0] cnt_q;
  // =====================================================
  // zero cross level toggles each half electrical cycle
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cnt_q <= 16'h0000;
      zero_cross_level <= 1'b0;
    end else if (run) begin
      if (cnt_q == half_period - 16'h0001) begin
        cnt_q <= 16'h0000;
        zero_cross_level <= ~zero_cross_level;
      end else begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end
  // =====================================================
  // one sample per request; stale value is not held
  always_ff @(posedge clk) begin
    current_valid <= cur_req & resetn;
    phase_current <= !resetn ? 12'h5A5 : (cur_req ? cur_level : ~phase_current);
  end
endmodule : clcomm_motor_model

// >>> clcomm_pkg.sv
// package of constants for the closed loop commutation tuning block
package clcomm_pkg;
  // =====================================================
  // register map (byte addresses)
  localparam logic [7:0] CLCOMM_CFG_OFF = 8'h00;
  localparam logic [7:0] CLCOMM_CMD_OFF = 8'h04;
  localparam logic [7:0] CLCOMM_AMP_OFF = 8'h08;
  localparam logic [7:0] CLCOMM_STAT_OFF = 8'h0C;
  localparam logic [7:0] CLCOMM_ADV_OFF = 8'h10;
  // =====================================================
  // config field positions
  localparam int CLCOMM_RATE_LSB = 0;
  localparam int CLCOMM_ATTN_LSB = 4;
  localparam int CLCOMM_MODE_BIT = 6;
  localparam int CLCOMM_HALF_BIT = 7;
  localparam int CLCOMM_CODE_LSB = 8;
  localparam int CLCOMM_ENA_BIT = 16;
  // =====================================================
  // reset values
  localparam logic [31:0] CLCOMM_CFG_RST = 32'h0000_0000;
  localparam logic [8:0] CLCOMM_CMD_RST = 9'h000;
  // =====================================================
  // timing
  localparam int CLCOMM_CLK_KHZ = 20000;
  // advance unit 2.5 us, in tenths of a microsecond
  localparam int CLCOMM_UNIT_TENTH_US = 25;
  localparam int CLCOMM_UNIT_CYC = CLCOMM_UNIT_TENTH_US * CLCOMM_CLK_KHZ / 10000;
  // rate limiter base step interval in cycles
  localparam int CLCOMM_RATE_BASE_CYC = 16;
  localparam logic [1:0] CLCOMM_RESP_OKAY = 2'b00;
  localparam logic [1:0] CLCOMM_RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {
    CLCOMM_IDLE = 2'b00,
    CLCOMM_WAIT = 2'b01,
    CLCOMM_FIRE = 2'b10
  } clcomm_adv_e;
endpackage : clcomm_pkg

// >>> clcomm_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module clcomm_sync (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic din,
  output logic dout
);
  logic [2:0] s_q;
  logic [2:0] s_d;
  logic o_q;
  logic o_d;
  always_comb begin
    s_d = {s_q[1:0], din};
    o_d = (s_q[1] == s_q[2]) ? s_q[2] : o_q;
  end
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_q <= 3'h0;
      o_q <= 1'b0;
    end else if (ce) begin
      s_q <= s_d;
      o_q <= o_d;
    end
  end
  assign dout = o_q;
endmodule : clcomm_sync

// >>> clcomm_top.sv
// closed loop commutation tuning: rate limit, attenuation, advance timing
// Contract
// - speed command slew limited by 3-bit rate
// - current sampled on each current_valid drives state estimate
// - feedback attenuated by 2-bit coefficient
// - phase drive fires ahead of zero cross
// - mode 0: advance equals base time
// - mode 1: base times (U-BEMF)/U
// - base = 2.5us mantissa shifted by exponent
// - codes 00, 28h, 58h give 0,80,640us
// - half-cycle bit selects both or rising edges
`timescale 1ns/1ns
module clcomm_top
  import clcomm_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [11:0] phase_current,
  input wire logic current_valid,
  input wire logic zero_cross_level,
  output logic [8:0] speed_command,
  output logic [11:0] current_feedback,
  output logic feedback_valid,
  output logic commutation_update,
  output logic phase_drive_strobe
);
  // =====================================================
  // bus slave
  logic [7:0] awaddr_q, awaddr_d;
  logic aw_have_q, aw_have_d, w_have_q, w_have_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d, do_write;
  logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d, cfg_q, cfg_d, adv_cyc_q;
  logic [3:0] wstrb_q, wstrb_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [8:0] target_q, target_d, cmd_q;
  logic [11:0] amp_u_q, amp_u_d, amp_b_q, amp_b_d, fb_q;
  always_comb begin
    awaddr_d = awaddr_q;
    aw_have_d = aw_have_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    w_have_d = w_have_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    cfg_d = cfg_q;
    target_d = target_q;
    amp_u_d = amp_u_q;
    amp_b_d = amp_b_q;
    if (s_axi_awvalid && !aw_have_q) begin
      awaddr_d = s_axi_awaddr;
      aw_have_d = 1'b1;
    end
    if (s_axi_wvalid && !w_have_q) begin
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
      w_have_d = 1'b1;
    end
    do_write = aw_have_q && w_have_q && !bvalid_q;
    if (do_write) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = CLCOMM_RESP_OKAY;
      case (awaddr_q)
        CLCOMM_CFG_OFF: begin
          for (int i = 0; i < 4; i++) begin
            if (wstrb_q[i]) cfg_d[i*8 +: 8] = wdata_q[i*8 +: 8];
          end
        end
        CLCOMM_CMD_OFF: begin
          if (wstrb_q[0]) target_d[7:0] = wdata_q[7:0];
          if (wstrb_q[1]) target_d[8] = wdata_q[8];
        end
        CLCOMM_AMP_OFF: begin
          if (wstrb_q[0]) amp_u_d[7:0] = wdata_q[7:0];
          if (wstrb_q[1]) amp_u_d[11:8] = wdata_q[11:8];
          if (wstrb_q[2]) amp_b_d[7:0] = wdata_q[23:16];
          if (wstrb_q[3]) amp_b_d[11:8] = wdata_q[27:24];
        end
        CLCOMM_STAT_OFF, CLCOMM_ADV_OFF: ;
        default: bresp_d = CLCOMM_RESP_SLVERR;
      endcase
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (s_axi_arvalid && !rvalid_q) begin
      rvalid_d = 1'b1;
      rresp_d = CLCOMM_RESP_OKAY;
      case (s_axi_araddr)
        CLCOMM_CFG_OFF: rdata_d = cfg_q;
        CLCOMM_CMD_OFF: rdata_d = {23'h000000, target_q};
        CLCOMM_AMP_OFF: rdata_d = {4'h0, amp_b_q, 4'h0, amp_u_q};
        CLCOMM_STAT_OFF: rdata_d = {11'h000, fb_q, cmd_q};
        CLCOMM_ADV_OFF: rdata_d = adv_cyc_q;
        default: begin
          rdata_d = 32'h0000_0000;
          rresp_d = CLCOMM_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    if (!resetn) begin
      awaddr_q <= 8'h00;
      aw_have_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      w_have_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= 2'h0;
      cfg_q <= CLCOMM_CFG_RST;
      target_q <= CLCOMM_CMD_RST;
      amp_u_q <= 12'h000;
      amp_b_q <= 12'h000;
    end else if (ce) begin
      awaddr_q <= awaddr_d;
      aw_have_q <= aw_have_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      w_have_q <= w_have_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      cfg_q <= cfg_d;
      target_q <= target_d;
      amp_u_q <= amp_u_d;
      amp_b_q <= amp_b_d;
    end
  end
  assign s_axi_awready = ce && !aw_have_q;
  assign s_axi_wready = ce && !w_have_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = ce && !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  // =====================================================
  // config fields
  logic [2:0] closed_loop_rate_limit;
  logic [1:0] feedback_attenuation;
  logic advance_mode_select;
  logic half_cycle_update_select;
  logic [6:0] advance_time_code;
  logic closed_loop_enable;
  assign closed_loop_rate_limit = cfg_q[CLCOMM_RATE_LSB +: 3];
  assign feedback_attenuation = cfg_q[CLCOMM_ATTN_LSB +: 2];
  assign advance_mode_select = cfg_q[CLCOMM_MODE_BIT];
  assign half_cycle_update_select = cfg_q[CLCOMM_HALF_BIT];
  assign advance_time_code = cfg_q[CLCOMM_CODE_LSB +: 7];
  assign closed_loop_enable = cfg_q[CLCOMM_ENA_BIT];
  // =====================================================
  // speed command rate limiter: interval = base << (7 - rate)
  logic [15:0] rate_cnt_q, rate_cnt_d;
  logic [8:0] cmd_d;
  logic [15:0] rate_top;
  always_comb begin
    rate_top = 16'(CLCOMM_RATE_BASE_CYC) << (3'd7 - closed_loop_rate_limit);
    rate_cnt_d = rate_cnt_q + 16'h0001;
    cmd_d = cmd_q;
    if (rate_cnt_q >= rate_top - 16'h0001) begin
      rate_cnt_d = 16'h0000;
      if (!closed_loop_enable) cmd_d = target_q;
      else if (cmd_q < target_q) cmd_d = cmd_q + 9'h001;
      else if (cmd_q > target_q) cmd_d = cmd_q - 9'h001;
    end
  end
  // =====================================================
  // current feedback attenuation
  logic [11:0] fb_d;
  logic signed [12:0] fb_err;
  logic fbv_q, fbv_d;
  always_comb begin
    fb_err = $signed({1'b0, phase_current}) - $signed({1'b0, fb_q});
    fb_d = fb_q;
    fbv_d = 1'b0;
    if (current_valid && closed_loop_enable) begin
      fb_d = fb_q + 12'(fb_err >>> feedback_attenuation);
      fbv_d = 1'b1;
    end
  end
  // =====================================================
  // zero cross detection
  logic zc_sync;
  logic zc_prev_q;
  logic zc_event;
  clcomm_sync u_zc_sync (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .din(zero_cross_level),
    .dout(zc_sync)
  );
  assign zc_event = closed_loop_enable && ((zc_sync && !zc_prev_q) || (half_cycle_update_select && !zc_sync && zc_prev_q));
  // =====================================================
  // advance time: ahead of the next predicted crossing
  logic [31:0] base_cyc;
  logic [31:0] adv_cyc_d;
  logic [43:0] scaled;
  logic [31:0] period_q, period_d, since_q, since_d, wait_q, wait_d;
  clcomm_adv_e st_q, st_d;
  logic upd_q, upd_d;
  logic fire_q, fire_d;
  always_comb begin
    base_cyc = (32'(advance_time_code[3:0]) * 32'(CLCOMM_UNIT_CYC)) << advance_time_code[6:4];
    scaled = 44'h0;
    if (!advance_mode_select) adv_cyc_d = base_cyc;
    else if (amp_b_q >= amp_u_q) adv_cyc_d = 32'h0;
    else begin
      scaled = 44'(base_cyc) * 44'(amp_u_q - amp_b_q);
      adv_cyc_d = 32'(scaled / 44'(amp_u_q));
    end
    since_d = since_q + 32'h1;
    period_d = period_q;
    wait_d = wait_q;
    st_d = st_q;
    upd_d = zc_event;
    fire_d = 1'b0;
    if (zc_event) begin
      period_d = since_q;
      since_d = 32'h0;
    end
    case (st_q)
      CLCOMM_IDLE: begin
        if (zc_event) begin
          // wait period - advance, firing ahead of the next crossing
          wait_d = (since_q > adv_cyc_q) ? since_q - adv_cyc_q : 32'h0;
          st_d = CLCOMM_WAIT;
        end
      end
      CLCOMM_WAIT: begin
        if (wait_q == 32'h0) st_d = CLCOMM_FIRE;
        else wait_d = wait_q - 32'h1;
      end
      CLCOMM_FIRE: begin
        fire_d = 1'b1;
        st_d = CLCOMM_IDLE;
      end
      default: st_d = CLCOMM_IDLE;
    endcase
  end
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rate_cnt_q <= 16'h0000;
      cmd_q <= CLCOMM_CMD_RST;
      fb_q <= 12'h000;
      fbv_q <= 1'b0;
      zc_prev_q <= 1'b0;
      adv_cyc_q <= 32'h0;
      period_q <= 32'h0;
      since_q <= 32'h0;
      wait_q <= 32'h0;
      st_q <= CLCOMM_IDLE;
      upd_q <= 1'b0;
      fire_q <= 1'b0;
    end else if (ce) begin
      rate_cnt_q <= rate_cnt_d;
      cmd_q <= cmd_d;
      fb_q <= fb_d;
      fbv_q <= fbv_d;
      zc_prev_q <= zc_sync;
      adv_cyc_q <= adv_cyc_d;
      period_q <= period_d;
      since_q <= since_d;
      wait_q <= wait_d;
      st_q <= st_d;
      upd_q <= upd_d;
      fire_q <= fire_d;
    end
  end
  assign speed_command = cmd_q;
  assign current_feedback = fb_q;
  assign feedback_valid = fbv_q;
  assign commutation_update = upd_q;
  assign phase_drive_strobe = fire_q;
  // =====================================================
  // assertions
  property p_slew;
    @(posedge clk) disable iff (!resetn) (ce && closed_loop_enable && $past(closed_loop_enable) && $past(ce)) |-> (cmd_q - $past(cmd_q) <= 9'h001 || $past(cmd_q) - cmd_q <= 9'h001);
  endproperty
  a_slew: assert property (p_slew) else $error("speed command jumped");
  property p_fixed;
    @(posedge clk) disable iff (!resetn) (ce && !advance_mode_select && $stable(cfg_q)) |=> (adv_cyc_q == base_cyc || !$stable(cfg_q));
  endproperty
  a_fixed: assert property (p_fixed) else $error("fixed advance wrong");
  property p_clamp;
    @(posedge clk) disable iff (!resetn) (ce && advance_mode_select && amp_b_q >= amp_u_q) |=> (!$stable(amp_u_q) || !$stable(amp_b_q) || adv_cyc_q == 32'h0 || !ce);
  endproperty
  a_clamp: assert property (p_clamp) else $error("advance not clamped");
  property p_code80;
    @(posedge clk) disable iff (!resetn) (advance_time_code == 7'h28) |-> base_cyc == 32'd1600;
  endproperty
  a_code80: assert property (p_code80) else $error("code 28h not 80us");
  property p_code640;
    @(posedge clk) disable iff (!resetn) (advance_time_code == 7'h58) |-> base_cyc == 32'd12800;
  endproperty
  a_code640: assert property (p_code640) else $error("code 58h not 640us");
  property p_fire;
    @(posedge clk) disable iff (!resetn) (ce && st_q == CLCOMM_FIRE) |=> phase_drive_strobe;
  endproperty
  a_fire: assert property (p_fire) else $error("strobe missing");
  property p_full;
    @(posedge clk) disable iff (!resetn) (ce && !half_cycle_update_select && zc_event) |-> zc_sync;
  endproperty
  a_full: assert property (p_full) else $error("falling edge update in full mode");
  property p_fb;
    @(posedge clk) disable iff (!resetn) (ce && current_valid && closed_loop_enable) |=> feedback_valid;
  endproperty
  a_fb: assert property (p_fb) else $error("feedback not updated");
  property p_att0;
    @(posedge clk) disable iff (!resetn) (ce && current_valid && closed_loop_enable && feedback_attenuation == 2'h0) |=> current_feedback == $past(phase_current);
  endproperty
  a_att0: assert property (p_att0) else $error("zero attenuation not pass-through");
  c_fire: cover property (@(posedge clk) phase_drive_strobe);
  c_half: cover property (@(posedge clk) half_cycle_update_select && commutation_update);
  c_var: cover property (@(posedge clk) advance_mode_select && adv_cyc_q != 32'h0);
endmodule : clcomm_top

// >>> test_closed_loop_commutation_tuning.sv
// self-checking bench for the closed loop commutation tuning block
`timescale 1ns/1ns
module test_closed_loop_commutation_tuning;
  import clcomm_pkg::*;
  logic clk = 0, resetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, run = 0, creq = 0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rd;
  logic awr, wr, bv, arr, rv, fbv, upd, stb, zc, cv;
  logic [1:0] br, rr;
  logic [11:0] pc, fb, clev = 12'h000;
  logic [8:0] spd;
  int errors = 0, check_count = 0, seed = 32'h4d1b, cyc = 0, dly = 0, last_dly = 0, ncom = 0;
  always #25 clk = ~clk;
  clcomm_top i_dut (.clk(clk), .resetn(resetn), .ce(1'b1), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
    .phase_current(pc), .current_valid(cv), .zero_cross_level(zc), .speed_command(spd),
    .current_feedback(fb), .feedback_valid(fbv), .commutation_update(upd), .phase_drive_strobe(stb));
  clcomm_motor_model i_mot (.clk(clk), .resetn(resetn), .run(run), .half_period(16'd400),
    .cur_req(creq), .cur_level(clev), .zero_cross_level(zc), .phase_current(pc), .current_valid(cv));
  // =====================================================
  // cycle count, strobe delay after update, timeout
  always @(posedge clk) begin
    cyc++;
    if (upd === 1'b1) begin
      dly = 0;
      ncom++;
    end else dly++;
    if (stb === 1'b1) last_dly = dly;
    if (cyc == 40000) begin
      errors++;
      complete_run();
    end
  end
  task automatic complete_run;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk_val
  task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t resp %h exp %h", $time, g, e);
    end
  endtask : chk_resp
  // =====================================================
  // axi4-lite master
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic pa, pw;
    pa = 1;
    pw = 1;
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1;
    wv <= 1;
    bry <= 1;
    while (pa || pw) begin
      @(negedge clk);
      if (awr && awv) pa = 0;
      if (wr && wv) pw = 0;
      @(posedge clk);
      if (!pa) awv <= 0;
      if (!pw) wv <= 0;
    end
    do @(negedge clk); while (bv !== 1'b1);
    r = br;
    @(posedge clk);
    bry <= 0;
  endtask : axw
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    ara <= a;
    arv <= 1;
    rry <= 1;
    do @(negedge clk); while (arr !== 1'b1);
    @(posedge clk);
    arv <= 0;
    do @(negedge clk); while (rv !== 1'b1);
    d = rd;
    r = rr;
    @(posedge clk);
    rry <= 0;
  endtask : axr
  task automatic sample(input logic [11:0] s);
    int n;
    @(posedge clk);
    clev <= s;
    creq <= 1;
    @(posedge clk);
    creq <= 0;
    for (n = 0; n < 4 && fbv !== 1'b1; n++) @(negedge clk);
  endtask : sample
  function automatic logic [31:0] cfg(int rate, int att, int mode, int half, int code);
    return (1 << CLCOMM_ENA_BIT) | (code << CLCOMM_CODE_LSB) | (half << CLCOMM_HALF_BIT)
      | (mode << CLCOMM_MODE_BIT) | (att << CLCOMM_ATTN_LSB) | (rate << CLCOMM_RATE_LSB);
  endfunction : cfg
  function automatic logic [31:0] adv_exp(logic [6:0] c, logic m, int u, int b);
    int base;
    base = (c[3:0] * CLCOMM_UNIT_CYC) << c[6:4];
    if (!m) return base;
    if (b >= u) return 0;
    return base * (u - b) / u;
  endfunction : adv_exp
  // =====================================================
  // main sequence
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    int ex[3], c, s, st, t, iv, fe, h, pr;
    ex = '{0, 1600, 12800};
    repeat (8) @(posedge clk);
    resetn <= 1;
    axr(CLCOMM_CFG_OFF, d, r);
    chk_val(d, CLCOMM_CFG_RST);
    axr(CLCOMM_CMD_OFF, d, r);
    chk_val(d, {23'h0, CLCOMM_CMD_RST});
    axr(8'h14, d, r);
    chk_resp(r, CLCOMM_RESP_SLVERR);
    axw(8'h18, 32'hFFFF_FFFF, r);
    chk_resp(r, CLCOMM_RESP_SLVERR);
    $display("test regs done");
    for (int i = 0; i < 7; i++) begin
      c = (i == 0) ? 0 : (i == 1) ? 8'h28 : (i == 2) ? 8'h58 : ($random(seed) & 127);
      axw(CLCOMM_CFG_OFF, cfg(0, 0, 0, 0, c), r);
      axr(CLCOMM_ADV_OFF, d, r);
      chk_val(d, adv_exp(c, 0, 0, 0));
      if (i < 3) chk_val(d, ex[i]);
    end
    for (int b = 16; b <= 112; b += 48) begin
      axw(CLCOMM_AMP_OFF, (b << 16) | 64, r);
      axw(CLCOMM_CFG_OFF, cfg(0, 0, 1, 0, 8'h58), r);
      axr(CLCOMM_ADV_OFF, d, r);
      chk_val(d, adv_exp(7'h58, 1, 64, b));
      axw(CLCOMM_CFG_OFF, cfg(0, 0, 0, 0, 8'h28), r);
      axr(CLCOMM_ADV_OFF, d, r);
      chk_val(d, 1600);
    end
    $display("test advance done");
    fe = 0;
    axw(CLCOMM_CFG_OFF, cfg(0, 0, 0, 0, 0), r);
    sample(12'h000);
    for (int i = 0; i < 8; i++) begin
      c = $random(seed) & 3;
      s = $random(seed) & 12'hFFF;
      axw(CLCOMM_CFG_OFF, cfg(0, c, 0, 0, 0), r);
      sample(s[11:0]);
      fe = fe + ((s - fe) >>> c);
      chk_val({31'h0, fbv}, 1);
      chk_val({20'h0, fb}, fe);
    end
    $display("test feedback done");
    for (int i = 0; i < 3; i++) begin
      c = (i == 0) ? 7 : 4 + ($random(seed) & 3);
      iv = CLCOMM_RATE_BASE_CYC << (7 - c);
      t = $random(seed) & 15;
      axw(CLCOMM_CFG_OFF, cfg(c, 0, 0, 0, 0), r);
      st = spd;
      axw(CLCOMM_CMD_OFF, t, r);
      repeat (2 * iv) @(posedge clk);
      s = (spd > st) ? spd - st : st - spd;
      chk_val(s <= 3, 1);
      s = (t > st) ? t - st : st - t;
      repeat ((s + 2) * iv) @(posedge clk);
      chk_val({23'h0, spd}, t);
      axr(CLCOMM_STAT_OFF, d, r);
      chk_val(d & 32'h1FF, t);
    end
    // open loop: command follows target at the next tick
    axw(CLCOMM_CFG_OFF, cfg(7, 0, 0, 0, 0) & ~(32'h1 << CLCOMM_ENA_BIT), r);
    axw(CLCOMM_CMD_OFF, 32'h0000_01A5, r);
    repeat (2 * CLCOMM_RATE_BASE_CYC) @(posedge clk);
    chk_val({23'h0, spd}, 32'h0000_01A5);
    $display("test rate done");
    run <= 1;
    for (h = 1; h >= 0; h--) begin
      axw(CLCOMM_CFG_OFF, cfg(0, 0, 0, h, 8'h01), r);
      repeat (1600) @(posedge clk);
      st = ncom;
      repeat (3200) @(posedge clk);
      t = ncom - st;
      c = h ? 8 : 4;
      chk_val(t >= c - 1 && t <= c + 1, 1);
      pr = (h ? 400 : 800) - CLCOMM_UNIT_CYC;
      chk_val(last_dly >= pr - 4 && last_dly <= pr + 6, 1);
    end
    $display("test commutation done");
    complete_run();
  end
endmodule : test_closed_loop_commutation_tuning
